// *** sssm_cfg.svh ***
// Offsets, field positions and reset values of the strap and serial mode block
`ifndef SSSM_CFG_SVH
`define SSSM_CFG_SVH

`define SSSM_ADDR_W        4
`define SSSM_DATA_W        8
`define SSSM_SYNC_STAGES   2

`define SSSM_REG_CFG       4'h0
`define SSSM_REG_STAT      4'h1

`define SSSM_CFG_LPDIS_BIT 0
`define SSSM_CFG_PRES_BIT  1
`define SSSM_CFG_RST       8'h00

`define SSSM_ST_CLK_BIT    0
`define SSSM_ST_DAT_BIT    1
`define SSSM_ST_MODE_BIT   2
`define SSSM_ST_LPEN_BIT   3
`define SSSM_ST_INIT_BIT   4
`define SSSM_ST_CAP_BIT    5

`define SSSM_STRAP_RST     1'h0
`define SSSM_RDATA_NONE    8'h00

`endif

// *** sssm_partner.sv ***
// Far-side model of the shared two-wire pins: strap resistors and wired-AND
`timescale 1ns/1ps
module sssm_partner (
  input  wire logic scl_strap,
  input  wire logic sda_strap,
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  output logic      scl_pin,
  output logic      sda_pin
);
  // A party pulling low wins, else the strap level
  assign scl_pin = scl_strap & scl_oe_n;
  assign sda_pin = sda_strap & sda_oe_n;
endmodule

// *** sssm_pkg.sv ***
// Types of the strap and serial mode block
package sssm_pkg;

  typedef enum logic {
    SSSM_SMBUS_SLAVE,
    SSSM_I2C_MASTER
  } sssm_mode_t;

  typedef enum logic {
    SSSM_CAP_WAIT,
    SSSM_CAP_HELD
  } sssm_cap_t;

endpackage

// *** sssm_sync.sv ***
// Two-stage synchroniser, one chain per bit
`timescale 1ns/1ps
module sssm_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge clk) begin
        meta_r <= d[i];
        sync_r <= meta_r;
      end
      assign q[i] = sync_r;
    end
  endgenerate

endmodule

// *** sssm_top.sv ***
// Strap sampling at reset release and two-wire serial port mode selection
//
// Overview of operation
// - Mode select high: shared pins form the two-wire EEPROM master port.
// - Mode select low: shared pins form the SMBus slave port.
// - Clock strap low at reset release: downstream ports may initiate U1/U2.
// - Clock strap high: ports do not initiate U1/U2 but still accept it.
// - Data strap high makes the clock strap irrelevant.
// - Data strap high at reset release disables U1 and U2.
// - Data strap low at reset release keeps U1 and U2 enabled.
// - With EEPROM or SMBus present, the config disable bit decides instead.
`timescale 1ns/1ps
`include "sssm_cfg.svh"
module sssm_top (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    serial_mode_select,
  input  wire logic                    scl_in,
  output logic                         scl_out,
  output logic                         scl_oe_n,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_n,
  input  wire logic                    eng_scl_low,
  input  wire logic                    eng_sda_low,
  output logic                         eng_scl,
  output logic                         eng_sda,
  output logic                         i2c_master_en,
  output logic                         smbus_slave_en,
  output logic                         u1u2_initiate_en,
  output logic                         u1u2_accept_en,
  input  wire logic [`SSSM_ADDR_W-1:0] reg_addr,
  input  wire logic [`SSSM_DATA_W-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`SSSM_DATA_W-1:0] reg_rdata
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0]            pins_s;
  logic                  mode_s;
  logic                  scl_s;
  logic                  sda_s;

  sssm_sync #(.WIDTH(3)) u_sync (
    .clk (clk),
    .d   ({serial_mode_select, sda_in, scl_in}),
    .q   (pins_s)
  );

  assign scl_s  = pins_s[0];
  assign sda_s  = pins_s[1];
  assign mode_s = pins_s[2];

  ////////////////////////////////////////////////////////////////////////
  // Strap capture
  sssm_pkg::sssm_cap_t cap_r;
  sssm_pkg::sssm_cap_t cap_nxt;
  logic                  clk_strap_r;
  logic                  dat_strap_r;
  logic                  take_straps;
  logic                  held;

  // First edge with reset released takes the straps
  assign take_straps = (cap_r == sssm_pkg::SSSM_CAP_WAIT);
  assign held        = (cap_r == sssm_pkg::SSSM_CAP_HELD);

  always_comb begin
    case (cap_r)
      sssm_pkg::SSSM_CAP_WAIT: cap_nxt = sssm_pkg::SSSM_CAP_HELD;
      sssm_pkg::SSSM_CAP_HELD: cap_nxt = sssm_pkg::SSSM_CAP_HELD;
      default:                 cap_nxt = sssm_pkg::SSSM_CAP_WAIT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cap_r       <= sssm_pkg::SSSM_CAP_WAIT;
      clk_strap_r <= `SSSM_STRAP_RST;
      dat_strap_r <= `SSSM_STRAP_RST;
    end else begin
      cap_r <= cap_nxt;
      if (take_straps) begin
        clk_strap_r <= scl_s;
        dat_strap_r <= sda_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial mode and pin steering
  sssm_pkg::sssm_mode_t mode;

  assign mode = mode_s ? sssm_pkg::SSSM_I2C_MASTER : sssm_pkg::SSSM_SMBUS_SLAVE;
  assign i2c_master_en  = held && (mode == sssm_pkg::SSSM_I2C_MASTER);
  assign smbus_slave_en = held && (mode == sssm_pkg::SSSM_SMBUS_SLAVE);

  // Pins stay released until the straps are safely taken
  logic scl_drv_r;
  logic sda_drv_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_drv_r <= 1'h0;
      sda_drv_r <= 1'h0;
    end else begin
      scl_drv_r <= i2c_master_en && eng_scl_low;
      sda_drv_r <= (i2c_master_en || smbus_slave_en) && eng_sda_low;
    end
  end

  assign scl_out  = 1'h0;
  assign sda_out  = 1'h0;
  assign scl_oe_n = !scl_drv_r;
  assign sda_oe_n = !sda_drv_r;
  assign eng_scl  = scl_s;
  assign eng_sda  = sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [`SSSM_DATA_W-1:0] cfg_r;
  logic [`SSSM_DATA_W-1:0] stat;
  logic                    cfg_lpdis;
  logic                    cfg_pres;
  logic                    hit_cfg;
  logic                    hit_stat;
  logic [`SSSM_DATA_W-1:0] rdata_nxt;

  assign hit_cfg   = (reg_addr == `SSSM_REG_CFG);
  assign hit_stat  = (reg_addr == `SSSM_REG_STAT);
  assign cfg_lpdis = cfg_r[`SSSM_CFG_LPDIS_BIT];
  assign cfg_pres  = cfg_r[`SSSM_CFG_PRES_BIT];

  always_comb begin
    stat                    = `SSSM_RDATA_NONE;
    stat[`SSSM_ST_CLK_BIT]  = clk_strap_r;
    stat[`SSSM_ST_DAT_BIT]  = dat_strap_r;
    stat[`SSSM_ST_MODE_BIT] = mode_s;
    stat[`SSSM_ST_LPEN_BIT] = u1u2_accept_en;
    stat[`SSSM_ST_INIT_BIT] = u1u2_initiate_en;
    stat[`SSSM_ST_CAP_BIT]  = held;
  end

  assign rdata_nxt = !reg_rd   ? `SSSM_RDATA_NONE :
                     hit_cfg  ? cfg_r :
                     hit_stat ? stat : `SSSM_RDATA_NONE;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_r     <= `SSSM_CFG_RST;
      reg_rdata <= `SSSM_RDATA_NONE;
    end else begin
      reg_rdata <= rdata_nxt;
      if (reg_wr && hit_cfg) begin
        cfg_r <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Low-power link policy
  logic lp_en;
  logic init_ok;

  // Config overrides straps; data strap overrides clock strap
  assign lp_en   = cfg_pres ? !cfg_lpdis : !dat_strap_r;
  assign init_ok = cfg_pres || dat_strap_r || !clk_strap_r;
  assign u1u2_accept_en   = held && lp_en;
  assign u1u2_initiate_en = held && lp_en && init_ok;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_strap_take_edge: assert property (
    nrst && take_straps |=> (clk_strap_r == $past(scl_s)) && (dat_strap_r == $past(sda_s)))
    else $error("Straps not taken at reset release");
  a_strap_hold_value: assert property (
    held |=> $stable(clk_strap_r) && $stable(dat_strap_r))
    else $error("Strap value changed after capture");
  a_i2c_mode_select: assert property (
    held && mode_s |-> i2c_master_en && !smbus_slave_en)
    else $error("Master port not selected");
  a_smbus_mode_select: assert property (
    held && !mode_s |-> smbus_slave_en && !i2c_master_en ##1 !scl_drv_r)
    else $error("Slave port not selected or clock driven");
  a_init_default_ok: assert property (
    held && !cfg_pres && !clk_strap_r && !dat_strap_r |-> u1u2_initiate_en)
    else $error("Initiation blocked with default straps");
  a_init_blocked_accept: assert property (
    held && !cfg_pres && clk_strap_r && !dat_strap_r |-> !u1u2_initiate_en && u1u2_accept_en)
    else $error("Clock strap policy wrong");
  a_clk_strap_ignored: assert property (
    held && !cfg_pres && dat_strap_r |-> u1u2_initiate_en == u1u2_accept_en)
    else $error("Clock strap not ignored");
  a_data_strap_off: assert property (
    held && !cfg_pres && dat_strap_r |-> !u1u2_accept_en && !u1u2_initiate_en)
    else $error("U1U2 not disabled by data strap");
  a_data_strap_on: assert property (
    held && !cfg_pres && !dat_strap_r |-> u1u2_accept_en)
    else $error("U1U2 not enabled with data strap low");
  a_cfg_override_bit: assert property (
    held && cfg_pres |-> (u1u2_accept_en == !cfg_lpdis) && (u1u2_initiate_en == !cfg_lpdis))
    else $error("Config bit did not decide U1U2");
  a_pins_idle_wait: assert property (
    !held |=> !scl_drv_r && !sda_drv_r)
    else $error("Pin driven before straps were taken");
  a_sda_drive_follow: assert property (
    held && eng_sda_low |=> !sda_oe_n)
    else $error("Data pin not pulled low on engine request");
  a_init_needs_accept: assert property (
    u1u2_initiate_en |-> u1u2_accept_en)
    else $error("Initiation allowed while U1U2 disabled");

  c_strap_clk_high: cover property (take_straps && scl_s && !sda_s ##1 held);
  c_strap_dat_high: cover property (take_straps && sda_s ##1 held);
  c_cfg_override: cover property (held && cfg_pres && cfg_lpdis ##1 !u1u2_accept_en);
  c_smbus_sda_drive: cover property (smbus_slave_en && eng_sda_low ##1 !sda_oe_n);
  c_i2c_scl_drive: cover property (i2c_master_en && eng_scl_low ##1 !scl_oe_n);

endmodule

// *** strap_sampling_serial_mode_tb.sv ***
// Self-checking bench for strap sampling and serial mode selection
`timescale 1ns/1ps
module strap_sampling_serial_mode_tb;
  logic       clk, nrst, mode, scl_strap, sda_strap, scl_pin, sda_pin;
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n, eng_scl_low, eng_sda_low;
  logic       eng_scl, eng_sda, i2c_en, smb_en, ini_en, acc_en, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int         bad_count = 0;
  int         tests_run = 0;

  sssm_partner u_far (.scl_strap(scl_strap), .sda_strap(sda_strap), .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n), .scl_pin(scl_pin), .sda_pin(sda_pin));

  sssm_top u_dut (.clk(clk), .nrst(nrst), .serial_mode_select(mode), .scl_in(scl_pin),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_pin), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .eng_scl_low(eng_scl_low), .eng_sda_low(eng_sda_low),
    .eng_scl(eng_scl), .eng_sda(eng_sda), .i2c_master_en(i2c_en), .smbus_slave_en(smb_en),
    .u1u2_initiate_en(ini_en), .u1u2_accept_en(acc_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rst(input logic c, input logic d, input logic m, input int hold);
    scl_strap <= c;
    sda_strap <= d;
    mode <= m;
    nrst <= 1'h0;
    repeat (hold) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(posedge clk);
    chk(reg_rdata, e);
  endtask

  task automatic t_straps();
    logic c, d, ac, in;
    for (int i = 0; i < 4; i++) begin
      c = i[0];
      d = i[1];
      ac = !d;
      in = !d && !c;
      rst(c, d, 1'h1, 4);
      chk(acc_en, ac);
      chk(ini_en, in);
      rd(4'h1, {2'h0, 1'h1, in, ac, 1'h1, d, c});
      scl_strap <= ~c;
      sda_strap <= ~d;
      repeat (5) @(posedge clk);
      chk({ini_en, acc_en}, {in, ac});
      rd(4'h1, {2'h0, 1'h1, in, ac, 1'h1, d, c});
    end
  endtask

  task automatic t_cfg();
    rst(1'h1, 1'h1, 1'h1, 4);
    wr(4'h0, 8'h02);
    chk({ini_en, acc_en}, 8'h03);
    wr(4'h0, 8'h03);
    chk({ini_en, acc_en}, 8'h00);
    wr(4'h5, 8'hFF);
    rd(4'h5, 8'h00);
    rd(4'h0, 8'h03);
  endtask

  task automatic t_mode();
    logic m;
    for (int i = 0; i < 2; i++) begin
      m = i[0];
      rst(1'h1, 1'h1, m, 4);
      chk({i2c_en, smb_en}, {m, !m});
      rd(4'h1, {2'h0, 1'h1, 2'h0, m, 2'h3});
      rd(4'h0, 8'h00);
      eng_scl_low <= 1'h1;
      eng_sda_low <= 1'h1;
      repeat (2) @(posedge clk);
      chk({scl_oe_n, sda_oe_n}, {!m, 1'h0});
      chk({scl_out, sda_out}, 8'h00);
      repeat (3) @(posedge clk);
      chk({eng_scl, eng_sda}, {!m, 1'h0});
      eng_scl_low <= 1'h0;
      eng_sda_low <= 1'h0;
      repeat (4) @(posedge clk);
      chk({scl_oe_n, sda_oe_n, eng_scl, eng_sda}, 8'h0F);
    end
  endtask

  initial begin
    {nrst, mode, scl_strap, sda_strap, eng_scl_low, eng_sda_low, reg_wr, reg_rd} = 8'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    @(posedge clk);
    rst(1'h0, 1'h0, 1'h1, 12);
    t_straps();
    t_cfg();
    t_mode();
    summarize();
  end

  // Guard against a hang
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule
